// ==== hdl/ffoc_pkg.sv ====
// Contract
// - Fall-through: first word shown after three edges
// - Write enable low stores data each edge
// - Output ready goes low once data shows
// - Almost-empty releases high at n+2 words
// - Half-full goes low at half depth plus two
// - Almost-full goes low after depth minus m writes
// - Depth is array plus one output word
// - Full raises input ready, writes ignored
// - First read from full lowers input ready
// - Almost-empty goes low at n+1 words
// - Empty raises output ready, reads ignored
// - Output ready three stages, input ready two
// - Offset registers take one of eight defaults
// - Load select at reset picks serial/parallel
// - Offsets read back only over parallel port
// - Offsets reprogrammable after reset, range 0..D-1
// - Sync flag timing updates on own side
// - Async flag timing asserts one side, releases other
// - Defaults chosen by load and two selects
package ffoc_pkg;
    localparam int DATA_W = 18;
    localparam int MEM_DEPTH = 512;
    localparam int ADDR_W = 9;
    localparam int PTR_W = 10;
    localparam int CNT_W = 10;
    localparam int OFS_W = 10;
    localparam int BUS_W = 32;
    localparam int BUS_AW = 4;
    localparam logic [CNT_W-1:0] FIFO_DEPTH = 10'h201;
    localparam logic [CNT_W-1:0] HALF_LEVEL = 10'h102;
    localparam logic [CNT_W-1:0] CNT_RESET = 10'h000;
    localparam logic [PTR_W-1:0] MEM_FULL = 10'h200;
    localparam logic [PTR_W-1:0] PTR_RESET = 10'h000;
    localparam logic [BUS_AW-1:0] REG_EMPTY_OFS = 4'h0;
    localparam logic [BUS_AW-1:0] REG_FULL_OFS = 4'h4;
    localparam logic [BUS_AW-1:0] REG_STATUS = 4'h8;
    localparam logic [BUS_AW-1:0] REG_SERIAL = 4'hc;
    localparam logic [BUS_W-1:0] BUS_RESET = 32'h0000_0000;
    localparam logic [OFS_W-1:0] OFS_3 = 10'h003;
    localparam logic [OFS_W-1:0] OFS_7 = 10'h007;
    localparam logic [OFS_W-1:0] OFS_15 = 10'h00f;
    localparam logic [OFS_W-1:0] OFS_31 = 10'h01f;
    localparam logic [OFS_W-1:0] OFS_63 = 10'h03f;
    localparam logic [OFS_W-1:0] OFS_127 = 10'h07f;
    localparam logic [OFS_W-1:0] OFS_255 = 10'h0ff;
    localparam logic [OFS_W-1:0] OFS_511 = 10'h1ff;

    // Default offset pair by {load select, sel a, sel b}
    function automatic logic [OFS_W-1:0] ffoc_default_ofs(
        input logic ld,
        input logic sel_a,
        input logic sel_b
    );
        case ({ld, sel_a, sel_b})
            3'b001: ffoc_default_ofs = OFS_511;
            3'b010: ffoc_default_ofs = OFS_255;
            3'b011: ffoc_default_ofs = OFS_63;
            3'b101: ffoc_default_ofs = OFS_15;
            3'b100: ffoc_default_ofs = OFS_31;
            3'b110: ffoc_default_ofs = OFS_7;
            3'b111: ffoc_default_ofs = OFS_3;
            default: ffoc_default_ofs = OFS_127;
        endcase
    endfunction
endpackage

// ==== hdl/ffoc_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module ffoc_mem
    import ffoc_pkg::*;
(
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];
endmodule
`default_nettype wire

// ==== hdl/ffoc_fifo_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
module ffoc_fifo_flags
    import ffoc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic fall_through_select,
    input wire logic offset_load_select_n,
    input wire logic default_offset_sel_a,
    input wire logic default_offset_sel_b,
    input wire logic flag_timing_sync_select,
    input wire logic write_en_n,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic read_en_n,
    output logic [DATA_W-1:0] data_out,
    output logic output_ready_n,
    output logic input_ready_n,
    output logic half_full_flag_n,
    output logic almost_full_flag_n,
    output logic almost_empty_flag_n,
    input wire logic [BUS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [BUS_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [BUS_W-1:0] avs_readdata,
    output logic avs_waitrequest
);
    logic cfg_fall_through_timing;
    logic cfg_serial;
    logic cfg_sync_flags;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] next_wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] next_rd_ptr;
    logic [PTR_W-1:0] rd_ptr_d1;
    logic [PTR_W-1:0] wr_ptr_d1;
    logic [PTR_W-1:0] wr_ptr_d2;
    logic write_accept;
    logic read_accept;
    logic mem_avail;
    logic out_load;
    logic next_input_ready_n;
    logic next_output_ready_n;
    logic [DATA_W-1:0] next_data_out;
    logic [DATA_W-1:0] mem_rd_data;
    logic [CNT_W-1:0] word_count;
    logic [CNT_W-1:0] next_word_count;
    logic ae_hit;
    logic af_hit;
    logic next_half_full_flag_n;
    logic next_almost_full_flag_n;
    logic next_almost_empty_flag_n;
    logic [OFS_W-1:0] empty_ofs;
    logic [OFS_W-1:0] full_ofs;
    logic [OFS_W-1:0] next_empty_ofs;
    logic [OFS_W-1:0] next_full_ofs;
    logic bus_write;
    logic next_waitrequest;
    logic [BUS_W-1:0] next_readdata;

    // Byte-lane merge of a bus write into an offset register
    function automatic logic [OFS_W-1:0] merge_ofs(
        input logic [OFS_W-1:0] old,
        input logic [BUS_W-1:0] wd,
        input logic [3:0] be
    );
        merge_ofs = old;
        if (be[0]) begin
            merge_ofs[7:0] = wd[7:0];
        end
        if (be[1]) begin
            merge_ofs[OFS_W-1:8] = wd[OFS_W-1:8];
        end
    endfunction

    ffoc_mem u_mem (
        .clk(clk),
        .wr_en(write_accept),
        .wr_addr(wr_ptr[ADDR_W-1:0]),
        .wr_data(data_in),
        .rd_addr(rd_ptr[ADDR_W-1:0]),
        .rd_data(mem_rd_data)
    );

    // Mode straps caught while master reset is held
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_fall_through_timing <= fall_through_select;
            cfg_serial <= offset_load_select_n;
            cfg_sync_flags <= flag_timing_sync_select;
        end
    end

    // Write side; read pointer seen one stage late, flag one more
    always_comb begin
        write_accept = !write_en_n && !input_ready_n;
        next_wr_ptr = wr_ptr + PTR_W'(write_accept);
        next_input_ready_n = (next_wr_ptr - rd_ptr_d1) == MEM_FULL;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr <= PTR_RESET;
            rd_ptr_d1 <= PTR_RESET;
            input_ready_n <= 1'b1;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr_d1 <= rd_ptr;
            input_ready_n <= next_input_ready_n;
        end
    end

    // Read side; write pointer two stages, output register third
    always_comb begin
        mem_avail = wr_ptr_d2 != rd_ptr;
        read_accept = !read_en_n && !output_ready_n;
        if (output_ready_n) begin
            out_load = mem_avail && (cfg_fall_through_timing || !read_en_n);
        end else begin
            out_load = mem_avail && read_accept;
        end
        next_rd_ptr = rd_ptr + PTR_W'(out_load);
        next_output_ready_n = output_ready_n;
        if (out_load) begin
            next_output_ready_n = 1'b0;
        end else if (read_accept) begin
            next_output_ready_n = 1'b1;
        end
        next_data_out = out_load ? mem_rd_data : data_out;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_ptr <= PTR_RESET;
            wr_ptr_d1 <= PTR_RESET;
            wr_ptr_d2 <= PTR_RESET;
            output_ready_n <= 1'b1;
            data_out <= '0;
        end else begin
            rd_ptr <= next_rd_ptr;
            wr_ptr_d1 <= wr_ptr;
            wr_ptr_d2 <= wr_ptr_d1;
            output_ready_n <= next_output_ready_n;
            data_out <= next_data_out;
        end
    end

    // Word count includes the output register word
    always_comb begin
        next_word_count = word_count + CNT_W'(write_accept)
            - CNT_W'(read_accept);
        ae_hit = next_word_count <= (next_empty_ofs + 10'h001);
        af_hit = next_word_count >= (FIFO_DEPTH - next_full_ofs);
        next_half_full_flag_n = next_word_count < HALF_LEVEL;
        next_almost_empty_flag_n = almost_empty_flag_n;
        next_almost_full_flag_n = almost_full_flag_n;
        if (cfg_sync_flags) begin
            next_almost_empty_flag_n = !ae_hit;
            next_almost_full_flag_n = !af_hit;
        end else begin
            if (read_accept && ae_hit) begin
                next_almost_empty_flag_n = 1'b0;
            end else if (write_accept && !ae_hit) begin
                next_almost_empty_flag_n = 1'b1;
            end
            if (write_accept && af_hit) begin
                next_almost_full_flag_n = 1'b0;
            end else if (read_accept && !af_hit) begin
                next_almost_full_flag_n = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            word_count <= CNT_RESET;
            half_full_flag_n <= 1'b1;
            almost_full_flag_n <= 1'b1;
            almost_empty_flag_n <= 1'b0;
        end else begin
            word_count <= next_word_count;
            half_full_flag_n <= next_half_full_flag_n;
            almost_full_flag_n <= next_almost_full_flag_n;
            almost_empty_flag_n <= next_almost_empty_flag_n;
        end
    end

    // Offset programming: parallel words or serial bit shifts
    always_comb begin
        bus_write = avs_write && !avs_waitrequest;
        next_empty_ofs = empty_ofs;
        next_full_ofs = full_ofs;
        if (bus_write && !cfg_serial) begin
            if (avs_address == REG_EMPTY_OFS) begin
                next_empty_ofs = merge_ofs(empty_ofs, avs_writedata,
                    avs_byteenable);
            end else if (avs_address == REG_FULL_OFS) begin
                next_full_ofs = merge_ofs(full_ofs, avs_writedata,
                    avs_byteenable);
            end
        end else if (bus_write && avs_address == REG_SERIAL
                && avs_byteenable[0]) begin
            {next_empty_ofs, next_full_ofs} =
                {empty_ofs[OFS_W-2:0], full_ofs, avs_writedata[0]};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            empty_ofs <= ffoc_default_ofs(offset_load_select_n,
                default_offset_sel_a, default_offset_sel_b);
            full_ofs <= ffoc_default_ofs(offset_load_select_n,
                default_offset_sel_a, default_offset_sel_b);
        end else begin
            empty_ofs <= next_empty_ofs;
            full_ofs <= next_full_ofs;
        end
    end

    // Bus slave: one wait cycle, read data ready with the release
    always_comb begin
        next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
        next_readdata = avs_readdata;
        if (avs_read && avs_waitrequest) begin
            if (avs_address == REG_EMPTY_OFS) begin
                next_readdata = BUS_W'(empty_ofs);
            end else if (avs_address == REG_FULL_OFS) begin
                next_readdata = BUS_W'(full_ofs);
            end else if (avs_address == REG_STATUS) begin
                next_readdata = BUS_W'({cfg_sync_flags, cfg_serial,
                    cfg_fall_through_timing, almost_empty_flag_n, almost_full_flag_n,
                    half_full_flag_n, input_ready_n, output_ready_n,
                    word_count});
            end else begin
                next_readdata = BUS_RESET;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= BUS_RESET;
        end else begin
            avs_waitrequest <= next_waitrequest;
            avs_readdata <= next_readdata;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    AST_FALL_THROUGH: assert property (
        (cfg_fall_through_timing && word_count == CNT_RESET && write_accept)
        |-> output_ready_n [*4] ##1 !output_ready_n
    ) else $error("first word not shown after three edges");

    AST_WRITE_STORE: assert property (
        (write_accept && !read_accept)
        |=> word_count == $past(word_count) + 10'h001
    ) else $error("accepted write not counted");

    AST_OR_WITH_DATA: assert property (
        $fell(output_ready_n) |-> $past(mem_avail)
            && data_out == $past(mem_rd_data)
    ) else $error("output ready fell without data");

    AST_AE_LEVEL: assert property (
        cfg_sync_flags |-> almost_empty_flag_n
            == (word_count >= empty_ofs + 10'h002)
    ) else $error("almost-empty level wrong");

    AST_HALF_FULL: assert property (
        half_full_flag_n == (word_count < HALF_LEVEL)
    ) else $error("half-full level wrong");

    AST_AF_LEVEL: assert property (
        cfg_sync_flags |-> almost_full_flag_n
            == (word_count < FIFO_DEPTH - full_ofs)
    ) else $error("almost-full level wrong");

    AST_CAPACITY: assert property (
        word_count <= FIFO_DEPTH
    ) else $error("word count above depth");

    AST_FULL_BLOCKS: assert property (
        (input_ready_n && !write_en_n) |=> $stable(wr_ptr)
    ) else $error("write taken while full");

    AST_IR_RELEASE: assert property (
        (word_count == FIFO_DEPTH && read_accept)
        |-> ##3 !input_ready_n
    ) else $error("input ready not released two stages after read");

    AST_AE_DRAIN: assert property (
        (cfg_sync_flags && word_count == empty_ofs + 10'h002
            && read_accept && write_en_n) |=> !almost_empty_flag_n
    ) else $error("almost-empty not low at n+1");

    AST_EMPTY_IGNORE: assert property (
        (word_count == CNT_RESET && write_en_n)
        |=> word_count == CNT_RESET && output_ready_n
    ) else $error("read taken while empty");

    AST_STRAPS: assert property (
        $fell(srst) |-> cfg_serial == $past(offset_load_select_n)
            && cfg_fall_through_timing == $past(fall_through_select)
    ) else $error("straps not latched");

    AST_DEFAULTS: assert property (
        $fell(srst) |-> empty_ofs == full_ofs && empty_ofs ==
            ffoc_default_ofs($past(offset_load_select_n),
            $past(default_offset_sel_a), $past(default_offset_sel_b))
    ) else $error("default offsets not loaded");

    AST_PAR_LOAD: assert property (
        (bus_write && !cfg_serial && avs_address == REG_EMPTY_OFS
            && avs_byteenable == 4'hf)
        |=> empty_ofs == $past(avs_writedata[OFS_W-1:0])
    ) else $error("parallel offset write lost");

    AST_AF_ASYNC: assert property (
        (!cfg_sync_flags && $fell(almost_full_flag_n))
        |-> $past(write_accept)
    ) else $error("async almost-full asserted without write");

    AST_AE_ASYNC: assert property (
        (!cfg_sync_flags && $rose(almost_empty_flag_n))
        |-> $past(write_accept)
    ) else $error("async almost-empty released without write");

    COV_FULL: cover property (word_count == FIFO_DEPTH);
    COV_FALL: cover property (cfg_fall_through_timing ##1 $fell(output_ready_n));
    COV_HALF: cover property ($fell(half_full_flag_n));
    COV_SERIAL: cover property (bus_write && cfg_serial
        && avs_address == REG_SERIAL);
endmodule
`default_nettype wire

// ==== test/ffoc_far_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module ffoc_far_end
    import ffoc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [10:0] wr_quota,
    input wire logic [10:0] rd_quota,
    input wire logic rd_slow,
    input wire logic input_ready_n,
    input wire logic output_ready_n,
    input wire logic [DATA_W-1:0] data_out,
    output logic write_en_n,
    output logic [DATA_W-1:0] data_in,
    output logic read_en_n,
    output logic [10:0] wr_done,
    output logic [10:0] rd_done,
    output logic [10:0] rd_errs
);
    logic [10:0] next_wr_done;
    logic [10:0] next_rd_done;
    logic wr_take;
    logic rd_take;
    assign wr_take = !write_en_n && !input_ready_n;
    assign rd_take = !read_en_n && !output_ready_n;
    assign next_wr_done = wr_done + 11'(wr_take);
    assign next_rd_done = rd_done + 11'(rd_take);
    // Word held until taken; idle lines show an inverted pattern
    assign data_in = write_en_n ? ~DATA_W'(wr_done) :
        DATA_W'(wr_done + 11'h001);
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_done <= 11'h000;
            rd_done <= 11'h000;
            rd_errs <= 11'h000;
            write_en_n <= 1'b1;
            read_en_n <= 1'b1;
        end else begin
            wr_done <= next_wr_done;
            rd_done <= next_rd_done;
            write_en_n <= !(next_wr_done < wr_quota);
            // Slow reader idles one cycle after each request cycle
            read_en_n <= !(next_rd_done < rd_quota &&
                !(rd_slow && !read_en_n));
            if (rd_take && data_out !== DATA_W'(rd_done + 11'h001)) begin
                rd_errs <= rd_errs + 11'h001;
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
    import ffoc_pkg::*;
;
    logic clk, srst, ft, ld_n, sel_a, sel_b, sync_sel;
    logic write_en_n, read_en_n, rd_slow;
    logic [DATA_W-1:0] data_in, data_out;
    logic output_ready_n, input_ready_n, half_full_flag_n;
    logic almost_full_flag_n, almost_empty_flag_n;
    logic [BUS_AW-1:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [BUS_W-1:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable;
    logic [10:0] wq, rq, wr_done, rd_done, rd_errs;
    logic [9:0] dflt [8] = '{10'h07f, 10'h1ff, 10'h0ff, 10'h03f,
        10'h01f, 10'h00f, 10'h007, 10'h003};
    int mismatches, n_compared, k;

    always #5 clk = ~clk;

    ffoc_fifo_flags DUT (.clk(clk), .srst(srst),
        .fall_through_select(ft), .offset_load_select_n(ld_n),
        .default_offset_sel_a(sel_a), .default_offset_sel_b(sel_b),
        .flag_timing_sync_select(sync_sel), .write_en_n(write_en_n),
        .data_in(data_in), .read_en_n(read_en_n), .data_out(data_out),
        .output_ready_n(output_ready_n), .input_ready_n(input_ready_n),
        .half_full_flag_n(half_full_flag_n),
        .almost_full_flag_n(almost_full_flag_n),
        .almost_empty_flag_n(almost_empty_flag_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    ffoc_far_end far (.clk(clk), .srst(srst), .wr_quota(wq),
        .rd_quota(rq), .rd_slow(rd_slow), .input_ready_n(input_ready_n),
        .output_ready_n(output_ready_n), .data_out(data_out),
        .write_en_n(write_en_n), .data_in(data_in),
        .read_en_n(read_en_n), .wr_done(wr_done), .rd_done(rd_done),
        .rd_errs(rd_errs));

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic hang(input string what);
        mismatches++;
        $display("wrong value %s expected done seen timeout", what);
        results();
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] rdat);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rdat = avs_readdata;
        if (n >= 20) hang("waitrequest");
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input string nm, input logic [3:0] a,
        input logic [31:0] e);
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    task automatic rst(input logic [3:0] s);
        srst <= 1'b1;
        {ld_n, sel_a, sel_b, sync_sel} <= s;
        wq <= 11'h000;
        rq <= 11'h000;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
    endtask

    task automatic settle(input int w, input int r);
        int n;
        n = 0;
        while ((wr_done !== 11'(w) || rd_done !== 11'(r)) && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 4000) hang("transfer count");
        repeat (5) @(posedge clk);
    endtask

    initial begin
        {clk, srst, ft, ld_n, sel_a, sel_b, sync_sel, rd_slow} = 8'h60;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        {wq, rq} = '0;
        mismatches = 0;
        n_compared = 0;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rst({i[2:0], i[0]});
            chk("ready out", 32'h1, 32'(output_ready_n));
            chk("ae reset", 32'h0, 32'(almost_empty_flag_n));
            rd_chk("empty ofs", REG_EMPTY_OFS, 32'(dflt[i]));
            rd_chk("full ofs", REG_FULL_OFS, 32'(dflt[i]));
            bus(1'b0, REG_STATUS, 32'h0, q);
            chk("modes", {29'h0, i[0], i[2], 1'b1}, 32'(q[17:15]));
        end
        bus(1'b1, REG_EMPTY_OFS, 32'h55, q);
        rd_chk("serial keeps", REG_EMPTY_OFS, 32'h3);
        for (int b = 19; b >= 0; b--) begin
            bus(1'b1, REG_SERIAL, 32'({10'h004, 10'h006} >> b) & 32'h1,
                q);
        end
        rd_chk("serial n", REG_EMPTY_OFS, 32'h4);
        rd_chk("serial m", REG_FULL_OFS, 32'h6);
        rst(4'h1);
        bus(1'b1, REG_EMPTY_OFS, 32'h4, q);
        bus(1'b1, REG_FULL_OFS, 32'h6, q);
        rd_chk("par m", REG_FULL_OFS, 32'h6);
        wq <= 11'h001;
        k = 0;
        while (output_ready_n !== 1'b0 && k < 20) begin
            @(posedge clk);
            k++;
        end
        // Request edge, accept edge, three stages, then the look
        chk("first latency", 32'h6, 32'(k));
        chk("first word", 32'h1, 32'(data_out));
        wq <= 11'h005;
        settle(5, 0);
        chk("ready out", 32'h0, 32'(output_ready_n));
        chk("ae n+1", 32'h0, 32'(almost_empty_flag_n));
        wq <= 11'h006;
        settle(6, 0);
        chk("ae n+2", 32'h1, 32'(almost_empty_flag_n));
        wq <= 11'h101;
        settle(257, 0);
        chk("hf 257", 32'h1, 32'(half_full_flag_n));
        wq <= 11'h102;
        settle(258, 0);
        chk("hf 258", 32'h0, 32'(half_full_flag_n));
        wq <= 11'h1fa;
        settle(506, 0);
        chk("af 506", 32'h1, 32'(almost_full_flag_n));
        wq <= 11'h1fb;
        settle(507, 0);
        chk("af 507", 32'h0, 32'(almost_full_flag_n));
        wq <= 11'h202;
        settle(513, 0);
        chk("full", 32'h1, 32'(input_ready_n));
        bus(1'b0, REG_STATUS, 32'h0, q);
        chk("depth", 32'h201, 32'(q[9:0]));
        chk("refused", 32'h201, 32'(wr_done));
        wq <= 11'h201;
        rq <= 11'h001;
        settle(513, 1);
        chk("ir read", 32'h0, 32'(input_ready_n));
        rq <= 11'h007;
        settle(513, 7);
        chk("af release", 32'h1, 32'(almost_full_flag_n));
        rq <= 11'h100;
        settle(513, 256);
        chk("hf release", 32'h1, 32'(half_full_flag_n));
        rq <= 11'h1fb;
        settle(513, 507);
        chk("ae 6 left", 32'h1, 32'(almost_empty_flag_n));
        rq <= 11'h1fc;
        settle(513, 508);
        chk("ae 5 left", 32'h0, 32'(almost_empty_flag_n));
        rd_slow <= 1'b1;
        rq <= 11'h202;
        settle(513, 513);
        chk("empty", 32'h1, 32'(output_ready_n));
        bus(1'b0, REG_STATUS, 32'h0, q);
        chk("count 0", 32'h0, 32'(q[9:0]));
        chk("order", 32'h0, 32'(rd_errs));
        // Standard timing, async almost flags, n=1 and m=511
        ft <= 1'b0;
        rst(4'h0);
        bus(1'b1, REG_EMPTY_OFS, 32'h1, q);
        bus(1'b1, REG_FULL_OFS, 32'h1ff, q);
        bus(1'b0, REG_STATUS, 32'h0, q);
        chk("std modes", 32'h0, 32'(q[17:15]));
        wq <= 11'h003;
        settle(3, 0);
        chk("no fall", 32'h1, 32'(output_ready_n));
        chk("ae async up", 32'h1, 32'(almost_empty_flag_n));
        chk("af async low", 32'h0, 32'(almost_full_flag_n));
        rq <= 11'h002;
        settle(3, 2);
        chk("ae async low", 32'h0, 32'(almost_empty_flag_n));
        chk("af async up", 32'h1, 32'(almost_full_flag_n));
        chk("order std", 32'h0, 32'(rd_errs));
        results();
    end
endmodule
`default_nettype wire
